/* include/rxs_pkg.sv */
// Purpose: shared constants and carriers for the rx error statistics bank
// Assumes: one 25 MHz clock, synchronous active-low reset
// Notes: counters are clear-on-read, saturating; map 2 forwards to the pcs
package rxs_pkg;

   // memory map selectors
   localparam logic [3:0] RXS_MAP_MAC = 4'h1;
   localparam logic [3:0] RXS_MAP_PCS = 4'h2;

   // register offsets inside the mac map
   localparam logic [15:0] RXS_OFS_FCS = 16'h004E;
   localparam logic [15:0] RXS_OFS_SYM = 16'h004F;
   localparam logic [15:0] RXS_OFS_ALIGN = 16'h0050;
   localparam logic [15:0] RXS_OFS_OVF = 16'h0051;
   localparam logic [15:0] RXS_OFS_FILT = 16'h0052;

   // counter widths, limits and reset values
   localparam int RXS_ERR_W = 10;
   localparam logic [9:0] RXS_ERR_MAX = 10'h3FF;
   localparam logic [9:0] RXS_ERR_RST = 10'h000;
   localparam logic [31:0] RXS_FILT_MAX = 32'h0FFFFFFF;
   localparam logic [31:0] RXS_FILT_RST = 32'h00000000;
   localparam logic [15:0] RXS_PCS_UPPER = 16'h0000;
   localparam int RXS_N_ERR = 4;

   // index of each small counter in the array
   localparam int RXS_I_FCS = 0;
   localparam int RXS_I_SYM = 1;
   localparam int RXS_I_ALIGN = 2;
   localparam int RXS_I_OVF = 3;

   // one register access from the spi front end
   typedef struct packed {
      logic valid;
      logic write;
      logic [3:0] mms;
      logic [15:0] addr;
      logic [31:0] wdata;
   } rxs_req_s;

   // per-frame event pulses from the receive mac
   typedef struct packed {
      logic good;
      logic fcs_err;
      logic sym_err;
      logic align_err;
      logic ovf_abort;
      logic filt_drop;
   } rxs_ev_s;

   // forwarded access to the 16-bit pcs register set
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } rxs_pcs_s;

endpackage : rxs_pkg

/* verilog/rxs_stat_counters.sv */
// Purpose: receive error statistics counters with clear-on-read access
// Assumes: inputs synchronous to core_clk_in; event inputs are 1-cycle pulses
// Notes: read data appears one edge after the request is taken
// Behaviour
// - ten-bit counter of fcs mismatch drops
// - fcs counter saturates, clears when read
// - ten-bit counter of symbol error drops
// - ten-bit counter of non byte-aligned drops
// - ten-bit counter of rx overflow aborts
// - overflow aborts still reported as received ok
// - symbol, align, overflow counters saturate, clear-on-read
// - 32-bit counter of address filtered drops
// - filtered frames still reported as received ok
// - filtered counter saturates, clears when read
// - pcs map: upper bytes read zero, unwritable
// - pcs map aliases the pcs register set
module rxs_stat_counters
   import rxs_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire rxs_req_s req_in,
   input wire rxs_ev_s ev_in,
   input wire logic [15:0] pcs_rdata_in,
   output rxs_pcs_s pcs_out,
   output logic [31:0] rdata_out,
   output logic done_out,
   output logic rx_ok_out
);

   // saturating increment with clear; an event on the clearing cycle leaves a count of one
   function automatic logic [31:0] rxs_sat_inc(input logic [31:0] cnt, input logic ev,
                                               input logic clr, input logic [31:0] lim);
      logic [31:0] res;
      res = cnt;
      if (clr) begin
         res = ev ? 32'h00000001 : 32'h00000000;
      end else if (ev && cnt != lim) begin
         res = cnt + 32'h00000001;
      end
      return res;
   endfunction : rxs_sat_inc

   logic [RXS_ERR_W-1:0] err_cnt [RXS_N_ERR];
   logic [RXS_ERR_W-1:0] next_err_cnt [RXS_N_ERR];
   logic [31:0] filt_cnt;
   logic [31:0] next_filt_cnt;
   logic [31:0] hold;
   logic [31:0] next_hold;
   logic pend_rd;
   logic next_pend_rd;
   logic pend_pcs;
   logic next_pend_pcs;
   logic [31:0] next_rdata;
   logic next_done;
   logic next_rx_ok;
   rxs_pcs_s next_pcs;
   logic mac_rd;
   logic [RXS_N_ERR-1:0] err_ev;
   logic [RXS_N_ERR-1:0] err_clr;
   logic filt_clr;
   logic [31:0] tmp;

   // decode and next state of the counters and access pipeline
   always_comb begin
      mac_rd = req_in.valid && !req_in.write && req_in.mms == RXS_MAP_MAC;
      err_ev = {ev_in.ovf_abort, ev_in.align_err, ev_in.sym_err, ev_in.fcs_err};
      err_clr[RXS_I_FCS] = mac_rd && req_in.addr == RXS_OFS_FCS;
      err_clr[RXS_I_SYM] = mac_rd && req_in.addr == RXS_OFS_SYM;
      err_clr[RXS_I_ALIGN] = mac_rd && req_in.addr == RXS_OFS_ALIGN;
      err_clr[RXS_I_OVF] = mac_rd && req_in.addr == RXS_OFS_OVF;
      filt_clr = mac_rd && req_in.addr == RXS_OFS_FILT;
      for (int i = 0; i < RXS_N_ERR; i++) begin
         tmp = rxs_sat_inc({22'h000000, err_cnt[i]}, err_ev[i], err_clr[i],
                           {22'h000000, RXS_ERR_MAX});
         next_err_cnt[i] = tmp[RXS_ERR_W-1:0];
      end
      // filtered drops, 32-bit saturating
      // the limit keeps the top nibble clear, so bits 31:28 never fill
      next_filt_cnt = rxs_sat_inc(filt_cnt, ev_in.filt_drop, filt_clr, RXS_FILT_MAX);
      // value before the clear is what the host sees; unused bits read zero
      // captured at the taking edge, so a count landing in the same cycle
      // goes to the freshly cleared counter instead of being lost
      next_hold = 32'h00000000;
      for (int i = 0; i < RXS_N_ERR; i++) begin
         if (err_clr[i]) begin
            next_hold = {22'h000000, err_cnt[i]};
         end
      end
      if (filt_clr) begin
         next_hold = filt_cnt;
      end
      // map 2 goes straight to the pcs registers
      // only the low half is forwarded on writes
      // addr follows the bus every cycle; only rd and wr give it meaning
      next_pcs.rd = req_in.valid && !req_in.write && req_in.mms == RXS_MAP_PCS;
      next_pcs.wr = req_in.valid && req_in.write && req_in.mms == RXS_MAP_PCS;
      next_pcs.addr = req_in.addr;
      next_pcs.wdata = req_in.wdata[15:0];
      next_pend_rd = req_in.valid;
      next_pend_pcs = req_in.mms == RXS_MAP_PCS;
      // upper bytes of a pcs read are zero
      next_rdata = pend_pcs ? {RXS_PCS_UPPER, pcs_rdata_in} : hold;
      next_done = pend_rd;
      // overflow and filtered frames still count as good
      next_rx_ok = ev_in.good || ev_in.ovf_abort || ev_in.filt_drop;
   end

   // state registers; clock enable freezes everything
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < RXS_N_ERR; i++) begin
            err_cnt[i] <= RXS_ERR_RST;
         end
         filt_cnt <= RXS_FILT_RST;
         hold <= 32'h00000000;
         pend_rd <= 1'b0;
         pend_pcs <= 1'b0;
         pcs_out <= '0;
         rdata_out <= 32'h00000000;
         done_out <= 1'b0;
         rx_ok_out <= 1'b0;
      end else if (ce_in) begin
         err_cnt <= next_err_cnt;
         filt_cnt <= next_filt_cnt;
         hold <= next_hold;
         pend_rd <= next_pend_rd;
         pend_pcs <= next_pend_pcs;
         pcs_out <= next_pcs;
         rdata_out <= next_rdata;
         done_out <= next_done;
         rx_ok_out <= next_rx_ok;
      end
   end

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!nrst_in);

   // each cause steps its own counter by one
   fcs_count_step_a: assert property (ce_in && ev_in.fcs_err && !err_clr[RXS_I_FCS]
      && err_cnt[RXS_I_FCS] != RXS_ERR_MAX
      |=> err_cnt[RXS_I_FCS] == $past(err_cnt[RXS_I_FCS]) + 10'h001)
      else $error("fcs counter did not step");
   sym_count_step_a: assert property (ce_in && ev_in.sym_err && !err_clr[RXS_I_SYM]
      && err_cnt[RXS_I_SYM] != RXS_ERR_MAX
      |=> err_cnt[RXS_I_SYM] == $past(err_cnt[RXS_I_SYM]) + 10'h001)
      else $error("symbol counter did not step");
   align_count_step_a: assert property (ce_in && ev_in.align_err && !err_clr[RXS_I_ALIGN]
      && err_cnt[RXS_I_ALIGN] != RXS_ERR_MAX
      |=> err_cnt[RXS_I_ALIGN] == $past(err_cnt[RXS_I_ALIGN]) + 10'h001)
      else $error("align counter did not step");
   ovf_count_step_a: assert property (ce_in && ev_in.ovf_abort && !err_clr[RXS_I_OVF]
      && err_cnt[RXS_I_OVF] != RXS_ERR_MAX
      |=> err_cnt[RXS_I_OVF] == $past(err_cnt[RXS_I_OVF]) + 10'h001)
      else $error("overflow counter did not step");
   // a register write never moves the fcs counter
   mac_write_a: assert property (ce_in && req_in.valid && req_in.write && !ev_in.fcs_err
      |=> err_cnt[RXS_I_FCS] == $past(err_cnt[RXS_I_FCS]))
      else $error("register write changed the fcs counter");

   // a full counter holds instead of wrapping
   fcs_saturate_a: assert property (ce_in && err_cnt[RXS_I_FCS] == RXS_ERR_MAX
      && !err_clr[RXS_I_FCS] |=> err_cnt[RXS_I_FCS] == RXS_ERR_MAX)
      else $error("fcs counter wrapped");
   sym_saturate_a: assert property (ce_in && err_cnt[RXS_I_SYM] == RXS_ERR_MAX
      && !err_clr[RXS_I_SYM] |=> err_cnt[RXS_I_SYM] == RXS_ERR_MAX)
      else $error("symbol counter wrapped");
   align_saturate_a: assert property (ce_in && err_cnt[RXS_I_ALIGN] == RXS_ERR_MAX
      && !err_clr[RXS_I_ALIGN] |=> err_cnt[RXS_I_ALIGN] == RXS_ERR_MAX)
      else $error("align counter wrapped");
   ovf_saturate_a: assert property (ce_in && err_cnt[RXS_I_OVF] == RXS_ERR_MAX
      && !err_clr[RXS_I_OVF] |=> err_cnt[RXS_I_OVF] == RXS_ERR_MAX)
      else $error("overflow counter wrapped");
   // clearing read with no event leaves zero
   err_clear_a: assert property (ce_in && |err_clr && !(|(err_clr & err_ev))
      |=> (err_cnt[RXS_I_SYM] == RXS_ERR_RST || !$past(err_clr[RXS_I_SYM]))
          && (err_cnt[RXS_I_ALIGN] == RXS_ERR_RST || !$past(err_clr[RXS_I_ALIGN]))
          && (err_cnt[RXS_I_OVF] == RXS_ERR_RST || !$past(err_clr[RXS_I_OVF])))
      else $error("error counter not cleared by read");
   // event on the clearing read kept
   clear_race_a: assert property (ce_in && err_clr[RXS_I_FCS] && ev_in.fcs_err
      |=> err_cnt[RXS_I_FCS] == 10'h001)
      else $error("event lost on clearing read");

   ok_on_drop_a: assert property (ce_in && (ev_in.ovf_abort || ev_in.filt_drop)
      |=> rx_ok_out)
      else $error("dropped frame not reported as received");
   ok_quiet_a: assert property (ce_in && !ev_in.good && !ev_in.ovf_abort
      && !ev_in.filt_drop |=> !rx_ok_out)
      else $error("receive report without a frame");

   filt_count_step_a: assert property (ce_in && ev_in.filt_drop && !filt_clr
      && filt_cnt != RXS_FILT_MAX |=> filt_cnt == $past(filt_cnt) + 32'h00000001)
      else $error("filtered counter did not step");
   filt_saturate_a: assert property (ce_in && filt_cnt == RXS_FILT_MAX && !filt_clr
      |=> filt_cnt == RXS_FILT_MAX)
      else $error("filtered counter passed its limit");
   filt_read_a: assert property (ce_in && filt_clr && !ev_in.filt_drop ##1 ce_in
      |-> filt_cnt == RXS_FILT_RST ##1 rdata_out == $past(filt_cnt, 2) && done_out)
      else $error("filtered read returned wrong value or did not clear");

   // map 2 forwarded, upper half zero
   pcs_upper_zero_a: assert property (ce_in && pend_pcs && pend_rd
      |=> rdata_out[31:16] == RXS_PCS_UPPER)
      else $error("pcs read upper half not zero");
   pcs_write_low_a: assert property (ce_in && req_in.valid && req_in.write
      && req_in.mms == RXS_MAP_PCS
      |=> pcs_out.wr && pcs_out.wdata == $past(req_in.wdata[15:0]))
      else $error("pcs write not forwarded with its low half");
   pcs_alias_a: assert property (ce_in && req_in.valid && req_in.mms == RXS_MAP_PCS
      |=> (pcs_out.rd || pcs_out.wr) && pcs_out.addr == $past(req_in.addr))
      else $error("pcs access not forwarded");

   // main scenarios a run should reach
   fcs_sat_c: cover property (err_cnt[RXS_I_FCS] == RXS_ERR_MAX && ev_in.fcs_err);
   race_c: cover property (ce_in && filt_clr && ev_in.filt_drop);
   pcs_rd_c: cover property (pcs_out.rd ##1 done_out);
   mac_rd_c: cover property (ce_in && mac_rd && hold != 32'h00000000 ##1 done_out);
   ok_c: cover property (ce_in && ev_in.good ##1 rx_ok_out);

endmodule : rxs_stat_counters

/* tb/rxs_pcs_model.sv */
// Purpose: behavioural pcs register set seen through map 2
// Assumes: read data is sampled while the forwarded read stands
// Notes: 16 registers only; idle data inverted to expose stale sampling
module rxs_pcs_model
   import rxs_pkg::*;
(
   input wire logic core_clk_in,
   input wire rxs_pcs_s pcs_in,
   output logic [15:0] rdata_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] regs [16];
   always @(posedge core_clk_in) begin
      if (pcs_in.wr) begin
         regs[pcs_in.addr[3:0]] <= pcs_in.wdata;
      end
   end
   // released data never repeats the last value
   assign rdata_out = pcs_in.rd ? regs[pcs_in.addr[3:0]] : ~regs[pcs_in.addr[3:0]];
endmodule : rxs_pcs_model

/* tb/test_rx_error_statistics_counters.sv */
// Purpose: self-checking bench for the rx statistics counters
// Assumes: pcs model answers map 2 accesses
// Notes: filtered limit is too far to reach in a short run
module test_rx_error_statistics_counters import rxs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_in = 0, nrst_in = 0, ce_in = 1, done, rx_ok;
   rxs_req_s req = '0;
   rxs_ev_s ev = '0;
   rxs_pcs_s pcs;
   logic [15:0] pcs_rdata;
   logic [31:0] rdata, rd;
   int failures = 0, comparisons = 0, cycles = 0;
   rxs_stat_counters rxs_stat_counters_inst (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
      .ce_in(ce_in), .req_in(req), .ev_in(ev), .pcs_rdata_in(pcs_rdata), .pcs_out(pcs),
      .rdata_out(rdata), .done_out(done), .rx_ok_out(rx_ok));
   rxs_pcs_model rxs_pcs_model_inst (.core_clk_in(core_clk_in), .pcs_in(pcs),
      .rdata_out(pcs_rdata));
   initial begin
      forever #20 core_clk_in = ~core_clk_in;
   end
   // hang guard, well above the roughly 1130 cycles needed
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 8000) begin
         failures++;
         summarize();
      end
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // one access; an event may ride on the taking edge
   task automatic access(input logic wr, input logic [3:0] mms, input logic [15:0] addr,
                         input logic [31:0] wd, input rxs_ev_s e);
      req = '{1'b1, wr, mms, addr, wd};
      ev = e;
      @(posedge core_clk_in) #1;
      req.valid = 0;
      ev = '0;
      @(posedge core_clk_in) #1;
      check("done", {31'h0, done}, 32'h1);
      rd = rdata;
   endtask : access
   task automatic rd_chk(input string name, input logic [3:0] mms, input logic [15:0] addr,
                         input logic [31:0] exp);
      access(0, mms, addr, 0, '0);
      check(name, rd, exp);
   endtask : rd_chk
   task automatic pulse(input rxs_ev_s e, input int n);
      ev = e;
      repeat (n) @(posedge core_clk_in) #1;
      ev = '0;
   endtask : pulse
   // reset values, then a second reset over live counters
   task automatic t_reset();
      check("rx_ok reset", {31'h0, rx_ok}, 32'h0);
      for (int i = 0; i < 5; i++) begin
         rd_chk("reset", RXS_MAP_MAC, RXS_OFS_FCS + 16'(i), 32'h0);
      end
      pulse(6'b011111, 3);
      nrst_in = 0;
      repeat (2) @(posedge core_clk_in) #1;
      nrst_in = 1;
      check("rx_ok rerun", {31'h0, rx_ok}, 32'h0);
      for (int i = 0; i < 5; i++) begin
         rd_chk("rerun", RXS_MAP_MAC, RXS_OFS_FCS + 16'(i), 32'h0);
      end
      $display("reset test done");
   endtask : t_reset
   task automatic t_count();
      pulse(6'b100000, 1);
      check("rx_ok good", {31'h0, rx_ok}, 32'h1);
      for (int i = 0; i < 5; i++) begin
         pulse(6'b010000 >> i, i + 2);
         check("rx_ok", {31'h0, rx_ok}, {31'h0, i >= 3});
         rd_chk("count", RXS_MAP_MAC, RXS_OFS_FCS + 16'(i), 32'(i + 2));
         rd_chk("cleared", RXS_MAP_MAC, RXS_OFS_FCS + 16'(i), 32'h0);
      end
      $display("count test done");
   endtask : t_count
   task automatic t_sat();
      pulse(6'b011110, 1030);
      for (int i = 0; i < 4; i++) begin
         rd_chk("saturate", RXS_MAP_MAC, RXS_OFS_FCS + 16'(i), 32'h3FF);
      end
      $display("saturation test done");
   endtask : t_sat
   task automatic t_race();
      pulse(6'b010000, 5);
      access(0, RXS_MAP_MAC, RXS_OFS_FCS, 0, 6'b010000);
      check("race old", rd, 32'h5);
      rd_chk("race new", RXS_MAP_MAC, RXS_OFS_FCS, 32'h1);
      $display("race test done");
   endtask : t_race
   task automatic t_refuse();
      pulse(6'b010000, 2);
      access(1, RXS_MAP_MAC, RXS_OFS_FCS, 32'h3FF, '0);
      rd_chk("bad map", 4'h3, RXS_OFS_FCS, 32'h0);
      rd_chk("ro write", RXS_MAP_MAC, RXS_OFS_FCS, 32'h2);
      access(1, RXS_MAP_PCS, 16'h0003, 32'hA5A51234, '0);
      rd_chk("pcs", RXS_MAP_PCS, 16'h0003, 32'h00001234);
      ce_in = 0;
      pulse(6'b010000, 3);
      ce_in = 1;
      rd_chk("frozen", RXS_MAP_MAC, RXS_OFS_FCS, 32'h0);
      $display("refusal test done");
   endtask : t_refuse
   task automatic summarize();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (2) @(posedge core_clk_in);
      #1 nrst_in = 1;
      t_reset();
      t_count();
      t_sat();
      t_race();
      t_refuse();
      summarize();
   end
endmodule : test_rx_error_statistics_counters
